// ---- verilog/srgs_pkg.sv ----
// srgs_pkg: constants for the speed regulator with gain scheduling
// assumes one 125 MHz control clock; all settings arrive as plain ports
package srgs_pkg;
    // clock and control period
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CTRL_PERIOD_NS = 1_000_000;
    localparam int CTRL_CYCLES    = CTRL_PERIOD_NS / CLK_PERIOD_NS;
    // setting widths: gain lsb 0.01, time lsb 1 ms, frequency lsb 0.1 Hz
    localparam int GAIN_W = 16;
    localparam int TIME_W = 14;
    localparam int FREQ_W = 12;
    localparam int TAU_W  = 9;
    localparam int DATA_W = 16;
    localparam int NUM_DIN = 6;
    // ranges and defaults
    localparam logic [GAIN_W-1:0] GAIN_MAX     = 16'h7530;
    localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 16'h07D0;
    localparam logic [TIME_W-1:0] TIME_MAX     = 14'h2710;
    localparam logic [TIME_W-1:0] TIME_DEFAULT = 14'h01F4;
    localparam logic [FREQ_W-1:0] FSW_MAX      = 12'h0FA0;
    localparam logic [FREQ_W-1:0] FSW_DEFAULT  = 12'h0000;
    localparam logic [TAU_W-1:0]  TAU_MAX      = 9'h1F4;
    localparam logic [TAU_W-1:0]  TAU_DEFAULT  = 9'h004;
    // input function codes
    localparam logic [7:0] FN_INTEG_RESET = 8'h0E;
    localparam logic [7:0] FN_GAIN_SELECT = 8'h77;
    // monitor source and level codes
    localparam logic [7:0] MON_SRC_OUT_FREQ = 8'h02;
    localparam logic [7:0] MON_SRC_SPEED    = 8'h05;
    localparam logic [7:0] MON_LVL_UNIPOLAR = 8'h00;
    // fixed point
    localparam int RATIO_FRAC = 12;
    localparam int RAMP_FRAC  = 8;
    localparam int OUT_SHIFT  = 8;
    localparam int DIV_W      = 32;
    localparam int DIVISOR_W  = 16;
    localparam logic signed [31:0] INTEG_LIMIT = 32'sh4000_0000;
    localparam logic signed [17:0] IPART_LIMIT = 18'sh0_FFFF;
    localparam logic signed [27:0] OUT_POS     = 28'sh000_7FFF;
    localparam logic signed [27:0] OUT_NEG     = -28'sh000_8000;

    typedef enum logic [2:0] {
        SRGS_IDLE, SRGS_BLEND, SRGS_STEP, SRGS_INTEG, SRGS_FILT
    } srgs_state_e;
endpackage

// ---- verilog/srgs_div.sv ----
// srgs_div: serial restoring divider, one quotient bit per clock
// assumes start is a pulse while idle and the divisor is non-zero
`timescale 1ns/10ps
`default_nettype none
module srgs_div (
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic                            start,
    input  wire logic [srgs_pkg::DIV_W-1:0]      dividend,
    input  wire logic [srgs_pkg::DIVISOR_W-1:0]  divisor,
    output logic      [srgs_pkg::DIV_W-1:0]      quotient,
    output logic                                 done
);
    logic [srgs_pkg::DIVISOR_W-1:0] rem_r;
    logic [5:0]                     cnt_r;
    logic [srgs_pkg::DIVISOR_W:0]   shifted;

    assign shifted = {rem_r, quotient[srgs_pkg::DIV_W-1]};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quotient <= '0;
            rem_r    <= '0;
            cnt_r    <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                quotient <= dividend;
                rem_r    <= '0;
                cnt_r    <= 6'(srgs_pkg::DIV_W);
            end else if (cnt_r != '0) begin
                if (shifted >= {1'b0, divisor}) begin
                    rem_r    <= 16'(shifted - {1'b0, divisor});
                    quotient <= {quotient[srgs_pkg::DIV_W-2:0], 1'b1};
                end else begin
                    rem_r    <= shifted[srgs_pkg::DIVISOR_W-1:0];
                    quotient <= {quotient[srgs_pkg::DIV_W-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 6'd1;
                done  <= (cnt_r == 6'd1);
            end
        end
    end
endmodule // srgs_div
`default_nettype wire

// ---- verilog/srgs_core.sv ----
// srgs_core: pi speed regulator with low-speed gain blend, gain select,
// integral reset, first-order output delay and monitor routing
// assumes settings are static between control ticks; digital inputs are pins
// Behaviour
// - primary gain and integral time settable
// - second low-speed gain and integral time
// - switching frequency sets low-speed region
// - blend linearly toward low-speed set below switch
// - switch frequency zero uses primary set
// - input function E is integral reset
// - reset input clears integral, p only
// - input function 77 selects second gain
// - gain select overrides frequency scheduling of the gain; integral time stays scheduled
// - gain-select change ramps over primary integral time
// - first-order delay filter on regulator output
// - monitor code 2 routes output frequency to monitor 1, code 5 routes speed to monitor 2
`timescale 1ns/10ps
`default_nettype none
module srgs_core #(
    parameter int CTRL_CYCLES = srgs_pkg::CTRL_CYCLES
) (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic                              run,
    input  wire logic signed [srgs_pkg::DATA_W-1:0] speed_ref,
    input  wire logic signed [srgs_pkg::DATA_W-1:0] motor_speed,
    input  wire logic signed [srgs_pkg::DATA_W-1:0] output_freq,
    input  wire logic [srgs_pkg::GAIN_W-1:0]       primary_prop_gain,
    input  wire logic [srgs_pkg::TIME_W-1:0]       primary_integral_time,
    input  wire logic [srgs_pkg::GAIN_W-1:0]       low_speed_prop_gain,
    input  wire logic [srgs_pkg::TIME_W-1:0]       low_speed_integral_time,
    input  wire logic [srgs_pkg::FREQ_W-1:0]       gain_switch_frequency,
    input  wire logic [srgs_pkg::TAU_W-1:0]        regulator_delay_time,
    input  wire logic [srgs_pkg::NUM_DIN-1:0]      digital_in,
    input  wire logic [srgs_pkg::NUM_DIN-1:0][7:0] input_function_select,
    input  wire logic [7:0]                        monitor1_source_select,
    input  wire logic [7:0]                        monitor2_source_select,
    input  wire logic [7:0]                        monitor_level_select,
    output logic signed [srgs_pkg::DATA_W-1:0]     torque_ref,
    output logic signed [srgs_pkg::DATA_W-1:0]     monitor1_out,
    output logic signed [srgs_pkg::DATA_W-1:0]     monitor2_out,
    output logic [srgs_pkg::GAIN_W-1:0]            kp_active,
    output logic [srgs_pkg::TIME_W-1:0]            ti_active,
    output logic                                   integ_reset_active,
    output logic                                   gain_select_active,
    output logic                                   ctrl_tick
);
    localparam int RF = srgs_pkg::RAMP_FRAC;

    srgs_pkg::srgs_state_e state_r;
    logic [31:0]  tick_cnt_r;
    logic         launched_r;
    logic         div_start;
    logic         div_done;
    logic [31:0]  div_a;
    logic [15:0]  div_b;
    logic [31:0]  div_q;

    logic [srgs_pkg::FREQ_W-1:0] fsw_r;
    logic [srgs_pkg::TAU_W-1:0]  tau_r;
    logic [12:0]                 ratio_r;
    logic [15:0]                 freq_abs;
    logic                        sched_on;
    logic [15:0]                 kp_sched;
    logic [15:0]                 ti_sched;
    logic [15:0]                 kp_target;
    logic [23:0]                 kp_acc_r;
    logic [23:0]                 step_r;
    logic [23:0]                 step_use;
    logic [23:0]                 tgt24;
    logic [23:0]                 ramp_gap;
    logic                        ramp_on_r;
    logic                        gs_prev_r;
    logic                        chg_r;
    logic signed [16:0]          err_r;
    logic signed [31:0]          integ_r;
    logic signed [32:0]          integ_sum;
    logic signed [17:0]          ipart;
    logic signed [18:0]          pi_sum;
    logic signed [35:0]          prod;
    logic signed [27:0]          prod_sh;
    logic signed [15:0]          u_sat;
    logic signed [15:0]          y_r;
    logic signed [16:0]          filt_gap;

    // digital input synchronisers and function decode
    logic [srgs_pkg::NUM_DIN-1:0] din_s1, din_s2, din_s3, din_q;
    logic [srgs_pkg::NUM_DIN-1:0] is_reset, is_gsel;
    genvar gi;
    generate
        for (gi = 0; gi < srgs_pkg::NUM_DIN; gi++) begin : g_din
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    din_s1[gi] <= 1'b0;
                    din_s2[gi] <= 1'b0;
                    din_s3[gi] <= 1'b0;
                    din_q[gi]  <= 1'b0;
                end else begin
                    din_s1[gi] <= digital_in[gi];
                    din_s2[gi] <= din_s1[gi];
                    din_s3[gi] <= din_s2[gi];
                    if (din_s2[gi] == din_s3[gi]) begin
                        din_q[gi] <= din_s3[gi];
                    end
                end
            end
            assign is_reset[gi] = din_q[gi] &&
                (input_function_select[gi] == srgs_pkg::FN_INTEG_RESET);
            assign is_gsel[gi]  = din_q[gi] &&
                (input_function_select[gi] == srgs_pkg::FN_GAIN_SELECT);
        end
    endgenerate
    assign integ_reset_active = |is_reset;
    assign gain_select_active = |is_gsel;

    // linear blend b + (a - b) * r / 4096
    function automatic logic [15:0] blend(input logic [15:0] a, input logic [15:0] b,
                                          input logic [12:0] r);
        logic signed [31:0] d;
        logic signed [31:0] s;
        d = ($signed(32'(a)) - $signed(32'(b))) * $signed(32'(r));
        s = $signed(32'(b)) + (d >>> srgs_pkg::RATIO_FRAC);
        return s[15:0];
    endfunction

    // control tick divider
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= '0;
            ctrl_tick  <= 1'b0;
        end else begin
            ctrl_tick <= (tick_cnt_r == 32'(CTRL_CYCLES - 1));
            if (tick_cnt_r == 32'(CTRL_CYCLES - 1)) begin
                tick_cnt_r <= '0;
            end else begin
                tick_cnt_r <= tick_cnt_r + 32'd1;
            end
        end
    end

    // settings that only move while stopped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fsw_r <= srgs_pkg::FSW_DEFAULT;
            tau_r <= srgs_pkg::TAU_DEFAULT;
        end else if (!run) begin
            fsw_r <= gain_switch_frequency;
            tau_r <= regulator_delay_time;
        end
    end

    // gain schedule
    assign freq_abs = output_freq[15] ? 16'(-output_freq) : output_freq;
    assign sched_on = (fsw_r != '0) && (freq_abs < 16'(fsw_r));
    assign kp_sched = sched_on ? blend(primary_prop_gain, low_speed_prop_gain, ratio_r)
                               : primary_prop_gain;
    assign ti_sched = sched_on ? blend(16'(primary_integral_time),
                                       16'(low_speed_integral_time), ratio_r)
                               : 16'(primary_integral_time);
    assign kp_target = gain_select_active ? low_speed_prop_gain : kp_sched;
    assign tgt24     = {kp_target, 8'h00};
    assign ramp_gap  = (tgt24 >= kp_acc_r) ? tgt24 - kp_acc_r : kp_acc_r - tgt24;
    assign step_use  = chg_r ? ((div_q[23:0] == '0) ? 24'd1 : div_q[23:0]) : step_r;
    assign kp_active = kp_acc_r[23:RF];
    assign ti_active = ti_sched[srgs_pkg::TIME_W-1:0];

    // regulator arithmetic
    assign integ_sum = 33'(integ_r) + 33'(err_r);
    assign pi_sum    = 19'(err_r) + 19'(ipart);
    assign prod      = $signed({1'b0, kp_active}) * pi_sum;
    assign prod_sh   = prod[35:srgs_pkg::OUT_SHIFT];
    assign u_sat     = (prod_sh > srgs_pkg::OUT_POS) ? 16'sh7FFF :
                       (prod_sh < srgs_pkg::OUT_NEG) ? -16'sh8000 : prod_sh[15:0];
    assign filt_gap  = 17'(u_sat) - 17'(y_r);

    // divider operands per step
    always_comb begin
        div_a = '0;
        div_b = 16'd1;
        unique case (state_r)
            srgs_pkg::SRGS_IDLE: begin
            end
            srgs_pkg::SRGS_BLEND: begin
                div_a = {4'h0, freq_abs, 12'h000};
                div_b = (fsw_r == '0) ? 16'd1 : 16'(fsw_r);
            end
            srgs_pkg::SRGS_STEP: begin
                div_a = 32'(ramp_gap);
                div_b = (primary_integral_time == '0) ? 16'd1 : 16'(primary_integral_time);
            end
            srgs_pkg::SRGS_INTEG: begin
                div_a = integ_r[31] ? 32'(-integ_r) : 32'(integ_r);
                div_b = (ti_sched == '0) ? 16'd1 : ti_sched;
            end
            srgs_pkg::SRGS_FILT: begin
                div_a = filt_gap[16] ? 32'(-filt_gap) : 32'(filt_gap);
                div_b = 16'(tau_r) + 16'd1;
            end
        endcase
    end
    assign div_start = (state_r != srgs_pkg::SRGS_IDLE) && !launched_r;

    srgs_div u_div (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (div_start),
        .dividend (div_a),
        .divisor  (div_b),
        .quotient (div_q),
        .done     (div_done)
    );

    // sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r    <= srgs_pkg::SRGS_IDLE;
            launched_r <= 1'b0;
        end else begin
            if (div_start) begin
                launched_r <= 1'b1;
            end
            if (div_done) begin
                launched_r <= 1'b0;
            end
            unique case (state_r)
                srgs_pkg::SRGS_IDLE:  if (ctrl_tick) state_r <= srgs_pkg::SRGS_BLEND;
                srgs_pkg::SRGS_BLEND: if (div_done) state_r <= srgs_pkg::SRGS_STEP;
                srgs_pkg::SRGS_STEP:  if (div_done) state_r <= srgs_pkg::SRGS_INTEG;
                srgs_pkg::SRGS_INTEG: if (div_done) state_r <= srgs_pkg::SRGS_FILT;
                srgs_pkg::SRGS_FILT:  if (div_done) state_r <= srgs_pkg::SRGS_IDLE;
            endcase
        end
    end

    // error sample and integrator
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            err_r   <= '0;
            integ_r <= '0;
        end else if (state_r == srgs_pkg::SRGS_IDLE && ctrl_tick) begin
            err_r <= 17'(speed_ref) - 17'(motor_speed);
            if (integ_reset_active) begin
                integ_r <= '0;
            end else if (integ_sum > 33'(srgs_pkg::INTEG_LIMIT)) begin
                integ_r <= srgs_pkg::INTEG_LIMIT;
            end else if (integ_sum < -33'(srgs_pkg::INTEG_LIMIT)) begin
                integ_r <= -srgs_pkg::INTEG_LIMIT;
            end else begin
                integ_r <= integ_sum[31:0];
            end
        end
    end

    // blend ratio
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ratio_r <= '0;
        end else if (state_r == srgs_pkg::SRGS_BLEND && div_done) begin
            ratio_r <= div_q[12:0];
        end
    end

    // proportional gain ramp after a gain-select change
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            kp_acc_r  <= {srgs_pkg::GAIN_DEFAULT, 8'h00};
            step_r    <= '0;
            ramp_on_r <= 1'b0;
            gs_prev_r <= 1'b0;
            chg_r     <= 1'b0;
        end else if (state_r == srgs_pkg::SRGS_IDLE && ctrl_tick) begin
            gs_prev_r <= gain_select_active;
            chg_r     <= gain_select_active != gs_prev_r;
        end else if (state_r == srgs_pkg::SRGS_STEP && div_done) begin
            chg_r <= 1'b0;
            if (chg_r) begin
                step_r <= step_use;
            end
            if ((ramp_on_r || chg_r) && primary_integral_time != '0) begin
                if (ramp_gap <= step_use) begin
                    kp_acc_r  <= tgt24;
                    ramp_on_r <= 1'b0;
                end else begin
                    ramp_on_r <= 1'b1;
                    kp_acc_r  <= (tgt24 > kp_acc_r) ? kp_acc_r + step_use
                                                    : kp_acc_r - step_use;
                end
            end else begin
                kp_acc_r  <= tgt24;
                ramp_on_r <= 1'b0;
            end
        end
    end

    // integral share: accumulated error over integral time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ipart <= '0;
        end else if (state_r == srgs_pkg::SRGS_INTEG && div_done) begin
            if (integ_reset_active || ti_sched == '0) begin
                ipart <= '0;
            end else if (div_q > 32'(srgs_pkg::IPART_LIMIT)) begin
                ipart <= integ_r[31] ? -srgs_pkg::IPART_LIMIT : srgs_pkg::IPART_LIMIT;
            end else begin
                ipart <= integ_r[31] ? -18'(div_q) : 18'(div_q);
            end
        end
    end

    // first-order delay on the torque reference
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            y_r <= '0;
        end else if (state_r == srgs_pkg::SRGS_FILT && div_done) begin
            y_r <= filt_gap[16] ? y_r - div_q[15:0] : y_r + div_q[15:0];
        end
    end
    assign torque_ref = y_r;

    // monitor routing
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            monitor1_out <= '0;
            monitor2_out <= '0;
        end else begin
            monitor1_out <= '0;
            monitor2_out <= '0;
            if (monitor1_source_select == srgs_pkg::MON_SRC_OUT_FREQ) begin
                monitor1_out <= (monitor_level_select == srgs_pkg::MON_LVL_UNIPOLAR &&
                                 output_freq[15]) ? '0 : output_freq;
            end
            if (monitor2_source_select == srgs_pkg::MON_SRC_SPEED) begin
                monitor2_out <= (monitor_level_select == srgs_pkg::MON_LVL_UNIPOLAR &&
                                 motor_speed[15]) ? '0 : motor_speed;
            end
        end
    end
endmodule // srgs_core
`default_nettype wire

// ---- dv/srgs_core_sva.sv ----
// srgs_core_sva: port-level checks of the regulator core
// assumes one clock domain; bound onto every srgs_core instance
`timescale 1ns/10ps
`default_nettype none
module srgs_core_sva #(
    parameter int CTRL_CYCLES = srgs_pkg::CTRL_CYCLES
) (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               run,
    input wire logic signed [15:0] motor_speed,
    input wire logic signed [15:0] output_freq,
    input wire logic [13:0]        primary_integral_time,
    input wire logic [11:0]        gain_switch_frequency,
    input wire logic [5:0]         digital_in,
    input wire logic [5:0][7:0]    input_function_select,
    input wire logic [7:0]         monitor1_source_select,
    input wire logic [7:0]         monitor2_source_select,
    input wire logic [7:0]         monitor_level_select,
    input wire logic signed [15:0] monitor1_out,
    input wire logic signed [15:0] monitor2_out,
    input wire logic [15:0]        kp_active,
    input wire logic [13:0]        ti_active,
    input wire logic               integ_reset_active,
    input wire logic               gain_select_active,
    input wire logic               ctrl_tick
);
    logic [31:0]        cnt_r;
    logic               seen_r;
    logic [11:0]        fsw_r, fsw_tick_r;
    logic               want_ir, want_gs, uni;
    logic signed [15:0] mon1_exp, mon2_exp;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // raw input function requests
    always_comb begin
        want_ir = 1'b0;
        want_gs = 1'b0;
        for (int i = 0; i < 6; i++) begin
            want_ir |= digital_in[i] && input_function_select[i] == srgs_pkg::FN_INTEG_RESET;
            want_gs |= digital_in[i] && input_function_select[i] == srgs_pkg::FN_GAIN_SELECT;
        end
    end
    assign uni = monitor_level_select == srgs_pkg::MON_LVL_UNIPOLAR;
    assign mon1_exp = (monitor1_source_select != srgs_pkg::MON_SRC_OUT_FREQ ||
        uni && output_freq < 0) ? '0 : output_freq;
    assign mon2_exp = (monitor2_source_select != srgs_pkg::MON_SRC_SPEED ||
        uni && motor_speed < 0) ? '0 : motor_speed;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            seen_r <= 1'b0;
        end else if (ctrl_tick) begin
            cnt_r <= '0;
            seen_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
        end
    end
    // stopped-only switch frequency and its value at the tick
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fsw_r <= '0;
            fsw_tick_r <= 12'h001;
        end else begin
            if (!run) fsw_r <= gain_switch_frequency;
            if (ctrl_tick) fsw_tick_r <= fsw_r;
        end
    end

    sequence s_quiet;
        !ctrl_tick [*8];
    endsequence

    tick_pulse_a: assert property (ctrl_tick |=> s_quiet)
        else $error("tick longer than one cycle");
    tick_period_a: assert property (ctrl_tick && seen_r |-> cnt_r == CTRL_CYCLES - 1)
        else $error("control tick period wrong");
    mon1_route_a: assert property (1'b1 |=> monitor1_out == $past(mon1_exp))
        else $error("monitor 1 output wrong");
    mon2_route_a: assert property (1'b1 |=> monitor2_out == $past(mon2_exp))
        else $error("monitor 2 output wrong");
    ireset_dec_a: assert property (want_ir [*7] |-> integ_reset_active)
        else $error("integral reset not decoded");
    gsel_dec_a: assert property (!want_gs [*7] |-> !gain_select_active)
        else $error("gain select without input");
    kp_stand_a: assert property (cnt_r > 150 |-> $stable(kp_active))
        else $error("gain moved between updates");
    ti_primary_a: assert property (seen_r && fsw_tick_r == '0 && cnt_r > 150 |->
        ti_active == primary_integral_time)
        else $error("integral time not primary");
endmodule // srgs_core_sva

bind srgs_core srgs_core_sva #(.CTRL_CYCLES(CTRL_CYCLES)) srgs_core_sva_i (.*);
`default_nettype wire

// ---- dv/srgs_motor.sv ----
// srgs_motor: motor with direct speed feedback and a held-shaft mode
// assumes torque integrates into speed once per control tick
`timescale 1ns/10ps
`default_nettype none
module srgs_motor (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               ctrl_tick,
    input  wire logic signed [15:0] torque_ref,
    input  wire logic               hold,
    input  wire logic signed [15:0] hold_speed,
    output logic signed [15:0]      motor_speed
);
    logic signed [15:0] free_r;

    // inertia: a sixteenth of the torque per tick
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            free_r <= '0;
        end else if (ctrl_tick) begin
            free_r <= free_r + (torque_ref >>> 4);
        end
    end
    // held shaft gives a known speed error
    assign motor_speed = hold ? hold_speed : free_r;
endmodule // srgs_motor
`default_nettype wire

// ---- dv/speed_regulator_gain_schedule_bench.sv ----
// speed_regulator_gain_schedule_bench: directed tests of srgs_core
// assumes a short control period and a held-shaft motor
`timescale 1ns/10ps
`default_nettype none
module speed_regulator_gain_schedule_bench;
    localparam int CYC = 200;
    localparam int LIMIT = 30000;
    logic                  sys_clk, rst, run, hold, tick, ir_act, gs_act;
    logic signed [15:0]    sref, ofreq, hspd, mspd, torque, mon1, mon2, sp0;
    logic [15:0]           kp1, kp2, kp;
    logic [13:0]           ti1, ti2, ti;
    logic [11:0]           fsw;
    logic [8:0]            dly;
    logic [5:0]            din;
    logic [5:0][7:0]       fsel;
    logic [7:0]            sel1, sel2, lvl;
    int                    err_total, comparisons, cycles;

    srgs_core #(.CTRL_CYCLES(CYC)) srgs_core_i (
        .sys_clk(sys_clk), .rst(rst), .run(run), .speed_ref(sref), .motor_speed(mspd),
        .output_freq(ofreq), .primary_prop_gain(kp1), .primary_integral_time(ti1),
        .low_speed_prop_gain(kp2), .low_speed_integral_time(ti2),
        .gain_switch_frequency(fsw), .regulator_delay_time(dly), .digital_in(din),
        .input_function_select(fsel), .monitor1_source_select(sel1),
        .monitor2_source_select(sel2), .monitor_level_select(lvl), .torque_ref(torque),
        .monitor1_out(mon1), .monitor2_out(mon2), .kp_active(kp), .ti_active(ti),
        .integ_reset_active(ir_act), .gain_select_active(gs_act), .ctrl_tick(tick));
    srgs_motor srgs_motor_i (.sys_clk(sys_clk), .rst(rst), .ctrl_tick(tick),
        .torque_ref(torque), .hold(hold), .hold_speed(hspd), .motor_speed(mspd));

    always #4 sys_clk = ~sys_clk;

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // n control ticks, each until its update has landed
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk iff tick === 1'b1);
            repeat (150) @(negedge sys_clk);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            $display("mismatch run_length expected below %0d seen %0d", LIMIT, cycles);
            test_done();
        end
    end

    task automatic test_monitor();
        for (int k = 0; k < 3; k++) begin
            sel1 = (k == 1) ? 8'h00 : srgs_pkg::MON_SRC_OUT_FREQ;
            sel2 = (k == 1) ? 8'h00 : srgs_pkg::MON_SRC_SPEED;
            lvl = (k == 2) ? srgs_pkg::MON_LVL_UNIPOLAR : 8'h01;
            repeat (2) @(negedge sys_clk);
            chk("monitor1_out", (k == 0) ? 16'hFED4 : 16'h0000, mon1);
            chk("monitor2_out", (k == 0) ? 16'hFFCE : 16'h0000, mon2);
        end
        hspd = 16'h0000;
        run = 1'b1;
        $display("test monitor done");
    endtask

    task automatic test_p_only();
        logic [15:0] exp [4] = '{16'h0019, 16'h002B, 16'h0039, 16'h0043};
        for (int k = 0; k < 4; k++) begin
            ticks(1);
            chk("torque_ref", exp[k], torque);
            dly = 9'h000; // ignored while running
        end
        chk("integ_reset_active", 16'h0001, 16'(ir_act));
        chk("ti_active", 16'h0014, 16'(ti));
        din[0] = 1'b0;
        ticks(12);
        chk("torque_ref_rises", 16'h0001, 16'(torque > 100));
        $display("test p_only done");
    endtask

    task automatic test_blend();
        logic [15:0] fr [3] = '{16'h00C8, 16'h0000, 16'h0032};
        logic [15:0] ek [3] = '{16'h0200, 16'h0100, 16'h0180};
        logic [15:0] et [3] = '{16'h0014, 16'h000A, 16'h000F};
        kp1 = 16'h0200;
        run = 1'b0;
        fsw = 12'h064;
        repeat (2) @(negedge sys_clk);
        run = 1'b1;
        for (int k = 0; k < 3; k++) begin
            ofreq = fr[k];
            ticks(1);
            chk("kp_active", ek[k], kp);
            chk("ti_active", et[k], 16'(ti));
        end
        fsw = 12'h000;
        ticks(1);
        chk("kp_active_latched", 16'h0180, kp);
        $display("test blend done");
    endtask

    task automatic test_gain_select();
        ofreq = 16'h00C8;
        ticks(1);
        chk("kp_active", 16'h0200, kp);
        din[1] = 1'b1;
        ticks(8);
        chk("gain_select_active", 16'h0001, 16'(gs_act));
        chk("kp_ramping", 16'h0001, 16'(kp > 16'h0100 && kp < 16'h0200));
        chk("ti_active", 16'h0014, 16'(ti));
        ticks(25);
        chk("kp_active", 16'h0100, kp);
        $display("test gain_select done");
    endtask

    initial begin
        {sys_clk, run, cycles, err_total, comparisons} = '0;
        {rst, hold} = 2'b11;
        {sref, ofreq, hspd} = {16'h0064, 16'hFED4, 16'hFFCE};
        {kp1, kp2, ti1, ti2} = {16'h0100, 16'h0100, 14'h0014, 14'h000A};
        {fsw, dly, din} = {12'h000, 9'h003, 6'b00_0001};
        fsel = '0;
        fsel[0] = srgs_pkg::FN_INTEG_RESET;
        fsel[1] = srgs_pkg::FN_GAIN_SELECT;
        {sel1, sel2, lvl} = '0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk("kp_active_reset", srgs_pkg::GAIN_DEFAULT, kp);
        chk("torque_ref_reset", 16'h0000, torque);
        test_monitor();
        test_p_only();
        test_blend();
        test_gain_select();
        hold = 1'b0;
        @(negedge sys_clk);
        sp0 = mspd;
        ticks(20);
        chk("motor_speed_follows", 16'h0001, 16'(mspd > 0 && mspd < sp0));
        test_done();
    end
endmodule // speed_regulator_gain_schedule_bench
`default_nettype wire
